// >>> otpm_pkg.sv
// constants and types shared by the program memory port block
package otpm_pkg;
   localparam int          DW            = 8;
   localparam int          AW            = 16;
   localparam int          ROM_AW        = 13;
   localparam int          ROM_SIZE      = 8192;
   localparam int          RAM_SIZE      = 256;
   localparam logic [15:0] ROM_BASE_MCU  = 16'hE000;
   localparam logic [15:0] RAM_BASE      = 16'h0040;
   localparam logic [15:0] RAM_LAST      = 16'h013F;
   localparam logic [15:0] P0_DATA_ADDR  = 16'h0000;
   localparam logic [15:0] P0_DIR_ADDR   = 16'h0008;
   localparam logic [15:0] SC2_ADDR      = 16'h0039;
   localparam int          SC2_OSC_BIT   = 6;
   localparam logic [7:0]  P0_LATCH_RST  = 8'h00;
   localparam logic [7:0]  P0_DIR_RST    = 8'h00;
   localparam logic        OSC_EN_RST    = 1'b0;
   localparam logic [7:0]  ERASED        = 8'hFF;
   // port 3 bit positions in programming mode
   localparam int          P3_CTRL       = 2;
   localparam int          P3_OE_N       = 3;
   localparam int          P3_CE_N       = 4;
   localparam int          P3_STROBE_N   = 5;
   localparam int          P3_TOP_ADDR   = 7;
   // programming pulse, least time rounded up to whole cycles
   localparam int          CLK_NS        = 40;
   localparam int          PROG_PULSE_NS = 100000;
   localparam int          PROG_PULSE_CYC =
      (PROG_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [11:0] PULSE_LAST    = 12'(PROG_PULSE_CYC - 1);

   typedef enum logic [2:0] {
      RG_NONE = 3'b000,
      RG_ROM  = 3'b001,
      RG_RAM  = 3'b010,
      RG_P0D  = 3'b011,
      RG_P0C  = 3'b100,
      RG_SC2  = 3'b101
   } otpm_region_t;
endpackage

// >>> otpm_mem_if.sv
// link between the port logic and the one-time array
`timescale 1ns/1ns
interface otpm_mem_if;
   import otpm_pkg::*;
   logic [ROM_AW-1:0] rd_addr;
   logic [DW-1:0]     rd_data;
   logic              pg_en;
   logic [ROM_AW-1:0] pg_addr;
   logic [DW-1:0]     pg_data;
   modport mem  (input rd_addr, pg_en, pg_addr, pg_data, output rd_data);
   modport user (output rd_addr, pg_en, pg_addr, pg_data, input rd_data);
endinterface

// >>> otpm_array.sv
// one-time programmable array, registered read
`timescale 1ns/1ns
module otpm_array (
   input  wire logic   mclk,   // system clock
   otpm_mem_if.mem     m       // read and program port
);
   import otpm_pkg::*;

   typedef struct packed {
      logic [DW-1:0] rd_data;
   } otpm_arr_state_t;

   logic [DW-1:0]   cells [0:ROM_SIZE-1];
   otpm_arr_state_t s;
   otpm_arr_state_t next_s;

   // blank part reads all ones
   initial begin
      for (int i = 0; i < ROM_SIZE; i++) begin
         cells[i] = ERASED;
      end
   end

   // a pulse can only clear bits, as a fuse would
   always_ff @(posedge mclk) begin
      if (m.pg_en) begin
         cells[m.pg_addr] <= cells[m.pg_addr] & m.pg_data;
      end
   end

   always_comb begin
      next_s = s;
      next_s.rd_data = cells[m.rd_addr];
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   assign m.rd_data = s.rd_data;
endmodule

// >>> otpm_top.sv
// program memory port: run-mode decode and parallel programming pins
`timescale 1ns/1ns
module otpm_top (
   input  wire logic                    mclk,         // 25 MHz clock
   input  wire logic                    rst_n,        // async reset
   input  wire logic                    test_vpp,     // high with reset pin low: programming
   input  wire logic                    reset_pin_n,  // device reset pin
   input  wire logic [otpm_pkg::AW-1:0] cpu_addr,     // core address
   input  wire logic                    cpu_rd,       // read strobe
   input  wire logic                    cpu_wr,       // write strobe
   input  wire logic [otpm_pkg::DW-1:0] cpu_wdata,    // write data
   output logic      [otpm_pkg::DW-1:0] cpu_rdata,    // read data
   output logic                         cpu_rvalid,   // read data valid
   output logic                         low_freq_osc_enable, // slow osc
   output logic                         prog_mode,    // programming mode
   input  wire logic [otpm_pkg::DW-1:0] port0_in,     // port 0 pin level
   output logic      [otpm_pkg::DW-1:0] port0_out,    // port 0 drive
   output logic      [otpm_pkg::DW-1:0] port0_oe,     // port 0 enable
   input  wire logic [otpm_pkg::DW-1:0] port3_in      // port 3 pin level
);
   import otpm_pkg::*;

   // ==================================================================
   // state
   typedef struct packed {
      logic              mode_prog;
      logic [DW-1:0]     p0_latch;
      logic [DW-1:0]     p0_dir;
      logic              osc_en;
      logic [DW-1:0]     addr_lo;
      logic [DW-1:0]     addr_hi;
      logic              top_bit;
      logic              hit_q;
      logic [11:0]       pulse_cnt;
      logic              pulse_done;
      logic              pg_en;
      logic [ROM_AW-1:0] pg_addr;
      logic [DW-1:0]     pg_data;
      otpm_region_t      rd_reg;
      logic              rd_pend;
      logic [DW-1:0]     rd_hold;
      logic [DW-1:0]     cpu_rdata;
      logic              cpu_rvalid;
      logic [DW-1:0]     port0_out;
      logic [DW-1:0]     port0_oe;
   } otpm_state_t;

   otpm_state_t   s;
   otpm_state_t   next_s;
   logic [1:0]    rsync;
   logic          rst_s;
   logic [DW-1:0] p0_read;
   logic [DW-1:0] ram [0:RAM_SIZE-1];
   logic [DW-1:0] ram_q;
   logic          ram_we;
   logic [7:0]    ram_idx;
   logic          mcu_run;
   logic          hit;
   logic          ce_n;
   logic          oe_n;
   logic          strobe_n;
   logic          prog_rd;
   otpm_region_t  region;

   otpm_mem_if mif ();

   otpm_array u_array (
      .mclk (mclk),
      .m    (mif.mem)
   );

   // ==================================================================
   // decode
   function automatic otpm_region_t cpu_region(input logic [AW-1:0] a);
      otpm_region_t r;
      r = RG_NONE;
      if (a >= ROM_BASE_MCU)
         r = RG_ROM;
      else if (a >= RAM_BASE && a <= RAM_LAST)
         r = RG_RAM;
      else if (a == P0_DATA_ADDR)
         r = RG_P0D;
      else if (a == P0_DIR_ADDR)
         r = RG_P0C;
      else if (a == SC2_ADDR)
         r = RG_SC2;
      return r;
   endfunction

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         rsync <= 2'b00;
      else
         rsync <= {rsync[0], 1'b1};
   end
   assign rst_s = rsync[1];

   // input bits read the pin, output bits the latch
   for (genvar i = 0; i < DW; i++) begin : g_p0rd
      assign p0_read[i] = s.p0_dir[i] ? s.p0_latch[i] : port0_in[i];
   end

   assign ce_n     = port3_in[P3_CE_N];
   assign oe_n     = port3_in[P3_OE_N];
   assign strobe_n = port3_in[P3_STROBE_N];
   assign prog_rd  = s.mode_prog && !ce_n && !oe_n && strobe_n;
   assign mcu_run  = !test_vpp && reset_pin_n && !s.mode_prog;
   assign region   = cpu_region(cpu_addr);
   assign hit      = !s.top_bit && (s.addr_hi[7:5] == 3'b000);
   // plain decode only, no signature path on any address bit
   assign mif.rd_addr = s.mode_prog ? {s.addr_hi[4:0], s.addr_lo}
                                    : cpu_addr[ROM_AW-1:0];
   assign mif.pg_en   = s.pg_en;
   assign mif.pg_addr = s.pg_addr;
   assign mif.pg_data = s.pg_data;

   // ==================================================================
   // data memory
   assign ram_idx = 8'(cpu_addr - RAM_BASE);
   assign ram_we  = mcu_run && cpu_wr && (region == RG_RAM);

   always_ff @(posedge mclk) begin
      if (ram_we)
         ram[ram_idx] <= cpu_wdata;
      ram_q <= ram[ram_idx];
   end

   // ==================================================================
   // next state
   always_comb begin
      next_s            = s;
      next_s.pg_en      = 1'b0;
      next_s.rd_pend    = 1'b0;
      next_s.cpu_rvalid = 1'b0;
      next_s.mode_prog  = test_vpp && !reset_pin_n;
      // held reset returns to single-clock operation
      if (!reset_pin_n)
         next_s.osc_en = 1'b0;
      if (!s.mode_prog) begin
         next_s.port0_oe  = s.p0_dir;
         next_s.port0_out = s.p0_latch;
         next_s.hit_q     = 1'b0;
         if (mcu_run && cpu_wr) begin
            unique case (region)
               RG_P0D:  next_s.p0_latch = cpu_wdata;
               RG_P0C:  next_s.p0_dir   = cpu_wdata;
               // slow oscillator only on software request
               RG_SC2:  next_s.osc_en   = cpu_wdata[SC2_OSC_BIT];
               RG_NONE, RG_ROM, RG_RAM: ;
            endcase
         end
         if (mcu_run && cpu_rd) begin
            next_s.rd_pend = 1'b1;
            next_s.rd_reg  = region;
            next_s.rd_hold = 8'h00;
            unique case (region)
               RG_P0D:  next_s.rd_hold = p0_read;
               RG_P0C:  next_s.rd_hold = s.p0_dir;
               RG_SC2:  next_s.rd_hold[SC2_OSC_BIT] = s.osc_en;
               RG_NONE, RG_ROM, RG_RAM: ;
            endcase
         end
         if (s.rd_pend) begin
            next_s.cpu_rvalid = 1'b1;
            if (s.rd_reg == RG_ROM)
               next_s.cpu_rdata = mif.rd_data;
            else if (s.rd_reg == RG_RAM)
               next_s.cpu_rdata = ram_q;
            else
               next_s.cpu_rdata = s.rd_hold;
         end
      end else begin
         next_s.port0_oe  = 8'h00;
         next_s.port0_out = ERASED;
         next_s.hit_q     = hit;
         // address bytes and top bit taken while chip is idle
         if (ce_n) begin
            next_s.top_bit = port3_in[P3_TOP_ADDR];
            if (port3_in[P3_CTRL])
               next_s.addr_hi = port0_in;
            else
               next_s.addr_lo = port0_in;
         end
         // one burn per strobe pulse inside the array, once it has lasted long enough
         if (strobe_n || ce_n) begin
            next_s.pulse_cnt  = 12'h000;
            next_s.pulse_done = 1'b0;
         end else if (!s.pulse_done) begin
            next_s.pulse_cnt = s.pulse_cnt + 12'h001;
            if (s.pulse_cnt == PULSE_LAST) begin
               next_s.pulse_done = 1'b1;
               next_s.pg_en      = hit;
               next_s.pg_addr    = {s.addr_hi[4:0], s.addr_lo};
               next_s.pg_data    = port0_in;
            end
         end
         // verify read drives the stored byte, all ones outside the array
         if (prog_rd) begin
            next_s.port0_oe  = 8'hFF;
            next_s.port0_out = s.hit_q ? mif.rd_data : ERASED;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         s            <= '0;
         s.p0_latch   <= P0_LATCH_RST;
         s.p0_dir     <= P0_DIR_RST;
         s.osc_en     <= OSC_EN_RST;
         s.port0_out  <= ERASED;
         s.rd_reg     <= RG_NONE;
      end else begin
         s <= next_s;
      end
   end

   assign cpu_rdata           = s.cpu_rdata;
   assign cpu_rvalid          = s.cpu_rvalid;
   assign low_freq_osc_enable = s.osc_en;
   assign prog_mode           = s.mode_prog;
   assign port0_out           = s.port0_out;
   assign port0_oe            = s.port0_oe;

   // ==================================================================
   // checks
   a_rom_decode: assert property (
      @(posedge mclk) disable iff (!rst_s)
      mcu_run && cpu_rd && cpu_addr >= ROM_BASE_MCU
         |=> s.rd_pend && s.rd_reg == RG_ROM ##1 cpu_rvalid)
      else $error("run-mode memory window not decoded");

   a_osc_reset: assert property (
      @(posedge mclk) disable iff (!rst_s)
      !reset_pin_n |=> !low_freq_osc_enable)
      else $error("slow oscillator enabled during reset");

   a_ram_readback: assert property (
      @(posedge mclk) disable iff (!rst_s)
      (ram_we ##1 (mcu_run && cpu_rd && !cpu_wr
                  && cpu_addr == $past(cpu_addr)))
         |-> ##2 cpu_rdata == $past(cpu_wdata, 3))
      else $error("data memory lost a byte");

   a_prog_drive: assert property (
      @(posedge mclk) disable iff (!rst_s)
      prog_rd [*3] |=> port0_oe == 8'hFF)
      else $error("data not driven on port 0");

   a_strobe_quiet: assert property (
      @(posedge mclk) disable iff (!rst_s)
      s.mode_prog && (!strobe_n || oe_n || ce_n) |=> port0_oe == 8'h00)
      else $error("port 0 driven outside a verify read");

   a_no_signature: assert property (
      @(posedge mclk) disable iff (!rst_s)
      prog_rd && !s.hit_q |=> port0_out == ERASED)
      else $error("address outside array returned data");

   a_port_read: assert property (
      @(posedge mclk) disable iff (!rst_s)
      mcu_run && cpu_rd && region == RG_P0D
         |-> ##2 cpu_rvalid && cpu_rdata == $past(p0_read, 2))
      else $error("port read not pin for inputs");

   a_verify_data: assert property (
      @(posedge mclk) disable iff (!rst_s)
      prog_rd && s.hit_q |=> port0_out == $past(mif.rd_data))
      else $error("verify read returned wrong byte");
endmodule

// >>> otpm_prog_model.sv
// programmer model that drives the parallel programming pins
`timescale 1ns/1ns
module otpm_prog_model (
   input  wire logic                    mclk,        // system clock
   input  wire logic [otpm_pkg::DW-1:0] pin,         // port 0 pin level
   output logic                         test_vpp,    // programming voltage
   output logic                         reset_pin_n, // device reset pin
   output logic      [otpm_pkg::DW-1:0] port3,       // port 3 pin levels
   output logic      [otpm_pkg::DW-1:0] drv          // drive on port 0
);
   import otpm_pkg::*;
   // =============================================================
   // pin state
   initial begin
      test_vpp = 1'b0;
      reset_pin_n = 1'b1;
      port3 = 8'h38;
      drv = 8'h00;
   end
   task set_mode(input logic prog);
      @(negedge mclk);
      test_vpp = prog;
      reset_pin_n = !prog;
      port3 = 8'h38;
   endtask
   task drive(input logic [7:0] v);
      drv = v;
   endtask
   task set_addr(input logic [16:0] a);
      @(negedge mclk);
      port3[P3_CE_N] = 1'b1;
      port3[P3_TOP_ADDR] = a[16];
      port3[P3_CTRL] = 1'b1;
      drv = a[15:8];
      @(negedge mclk);
      port3[P3_CTRL] = 1'b0;
      drv = a[7:0];
   endtask
   task pulse(input int n, input logic [7:0] d);
      @(negedge mclk);
      port3[P3_CE_N] = 1'b0;
      port3[P3_STROBE_N] = 1'b0;
      drv = d;
      repeat (n) @(negedge mclk);
      port3[P3_STROBE_N] = 1'b1;
   endtask
   // read by enables only, never a signature
   task read(output logic [7:0] d);
      @(negedge mclk);
      port3[P3_CE_N] = 1'b0;
      port3[P3_OE_N] = 1'b0;
      // released line shows the inverse, not the stale byte
      drv = ~drv;
      repeat (4) @(negedge mclk);
      d = pin;
      port3[P3_OE_N] = 1'b1;
      port3[P3_CE_N] = 1'b1;
   endtask
   // verify each pulse, 25 tries at most
   task prog_byte(input logic [16:0] a, input logic [7:0] d,
                  output int tries);
      logic [7:0] r;
      tries = 0;
      r = ~d;
      while (r !== d && tries < 25) begin
         set_addr(a);
         pulse(PROG_PULSE_CYC, d);
         read(r);
         tries++;
      end
   endtask
endmodule

// >>> tb_otp_program_memory_port.sv
// testbench for run-mode decode and the programming pins
`timescale 1ns/1ns
module tb_otp_program_memory_port;
   import otpm_pkg::*;
   logic          mclk, rst_n, test_vpp, reset_pin_n, osc, prog_mode;
   logic          cpu_rd, cpu_wr, cpu_rvalid;
   logic [AW-1:0] cpu_addr;
   logic [DW-1:0] cpu_wdata, cpu_rdata, port0_in, port0_out, port0_oe;
   logic [DW-1:0] port3, drv, r;
   int            error_cnt, n_compared, tries;

   // design drive wins where enabled, programmer elsewhere
   assign port0_in = (port0_oe & port0_out) | (~port0_oe & drv);

   otpm_top u_dut (.mclk(mclk), .rst_n(rst_n), .test_vpp(test_vpp),
      .reset_pin_n(reset_pin_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
      .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_rvalid(cpu_rvalid), .low_freq_osc_enable(osc),
      .prog_mode(prog_mode), .port0_in(port0_in), .port0_out(port0_out),
      .port0_oe(port0_oe), .port3_in(port3));
   otpm_prog_model u_prog (.mclk(mclk),
      .pin(port0_in), .test_vpp(test_vpp), .reset_pin_n(reset_pin_n),
      .port3(port3), .drv(drv));

   always #20 mclk = ~mclk;

   // =============================================================
   // shared tasks
   task check(input string what, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task cpu_write(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(negedge mclk);
      cpu_wr = 1'b0;
   endtask
   task cpu_read(input logic [15:0] a, input logic [7:0] e);
      int n;
      @(negedge mclk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge mclk);
      cpu_rd = 1'b0;
      n = 0;
      while (cpu_rvalid !== 1'b1 && n < 6) begin
         @(negedge mclk);
         n++;
      end
      check("read latency", 8'(n), 8'h01);
      check("read data", cpu_rdata, e);
      if (n >= 6) tally_and_finish();
   endtask

   // =============================================================
   // scenarios
   task t_reset;
      check("osc at reset", 8'(osc), 8'h00);
      check("oe at reset", port0_oe, 8'h00);
      check("mode at reset", 8'(prog_mode), 8'h00);
   endtask
   task t_map;
      cpu_read(ROM_BASE_MCU, ERASED);
      cpu_write(ROM_BASE_MCU, 8'h00);
      cpu_read(ROM_BASE_MCU, ERASED);
      cpu_write(RAM_BASE, 8'h11);
      cpu_write(RAM_LAST, 8'hEE);
      cpu_read(RAM_BASE, 8'h11);
      cpu_read(RAM_LAST, 8'hEE);
      cpu_read(16'h0140, 8'h00);
      cpu_read(16'hDFFF, 8'h00);
   endtask
   // read issued the cycle right after a write to the same byte
   task t_ram_b2b;
      @(negedge mclk);
      cpu_addr = RAM_BASE + 16'h0001;
      cpu_wdata = 8'h5A;
      cpu_wr = 1'b1;
      @(negedge mclk);
      cpu_wr = 1'b0;
      cpu_rd = 1'b1;
      @(negedge mclk);
      cpu_rd = 1'b0;
      @(negedge mclk);
      check("b2b valid", 8'(cpu_rvalid), 8'h01);
      check("b2b data", cpu_rdata, 8'h5A);
   endtask
   task t_port;
      u_prog.drive(8'h3C);
      cpu_write(P0_DIR_ADDR, 8'h0F);
      cpu_write(P0_DATA_ADDR, 8'hA5);
      @(negedge mclk);
      check("dir", port0_oe, 8'h0F);
      check("latch", port0_out & 8'h0F, 8'h05);
      cpu_read(P0_DATA_ADDR, 8'h35);
      u_prog.drive(8'hC3);
      cpu_read(P0_DATA_ADDR, 8'hC5);
      cpu_write(P0_DIR_ADDR, 8'h00);
   endtask
   task t_prog;
      cpu_write(SC2_ADDR, 8'h40);
      @(negedge mclk);
      check("osc on", 8'(osc), 8'h01);
      u_prog.set_mode(1'b1);
      repeat (3) @(negedge mclk);
      check("osc cleared", 8'(osc), 8'h00);
      check("prog mode", 8'(prog_mode), 8'h01);
      // core writes must be ignored here
      cpu_write(RAM_BASE, 8'h55);
      u_prog.prog_byte(17'h00000, 8'hA5, tries);
      check("tries low", 8'(tries), 8'h01);
      u_prog.prog_byte(17'h01FFF, 8'h3C, tries);
      check("tries end", 8'(tries), 8'h01);
      u_prog.prog_byte(17'h00002, ERASED, tries);
      check("fill", 8'(tries), 8'h01);
      u_prog.set_addr(17'h00001);
      u_prog.pulse(PROG_PULSE_CYC - 1, 8'h00);
      u_prog.read(r);
      check("short pulse", r, ERASED);
      u_prog.set_addr(17'h02000);
      u_prog.read(r);
      check("out of range", r, ERASED);
      u_prog.set_addr(17'h10000);
      u_prog.read(r);
      check("top bit", r, ERASED);
      // bits only go 1 to 0, so this never verifies
      u_prog.prog_byte(17'h00000, 8'h5A, tries);
      check("retry cap", 8'(tries), 8'h19);
      u_prog.set_addr(17'h00000);
      u_prog.read(r);
      check("verify low", r, 8'h00);
      u_prog.set_addr(17'h01FFF);
      u_prog.read(r);
      check("verify end", r, 8'h3C);
      u_prog.set_mode(1'b0);
      repeat (4) @(negedge mclk);
      check("run mode", 8'(prog_mode), 8'h00);
      cpu_read(ROM_BASE_MCU, 8'h00);
      cpu_read(16'hFFFF, 8'h3C);
      cpu_read(RAM_BASE, 8'h11);
   endtask

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      cpu_addr = 16'h0000;
      cpu_rd = 1'b0;
      cpu_wr = 1'b0;
      cpu_wdata = 8'h00;
      error_cnt = 0;
      n_compared = 0;
      repeat (10) @(negedge mclk);
      t_reset();
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      t_map();
      t_ram_b2b();
      t_port();
      t_prog();
      tally_and_finish();
   end
endmodule
